// ---- tb/sbtc_top_tb.sv ----
`timescale 1ns/10ps
module sbtc_top_tb;
    import sbtc_pkg::*;

    // ------------------------------------------------------------
    // addresses and signals
    // ------------------------------------------------------------
    localparam logic [11:0] A_FLAG = {SBTC_IDX_FLAG, 2'b00};
    localparam logic [11:0] A_LO   = {SBTC_IDX_CNT_LO, 2'b00};
    localparam logic [11:0] A_HI   = {SBTC_IDX_CNT_HI, 2'b00};
    localparam logic [11:0] A_CTRL = {SBTC_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_EN   = {SBTC_IDX_ENABLE, 2'b00};
    localparam logic [11:0] A_BAD  = 12'h004;
    localparam int          OSC_SETTLE = 20;

    logic        mclk, rst_b, ce;
    logic [11:0] avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        instr_cycle_tick, core_sleep, capture_compare_reset, irq;
    logic        ext_clock_pin, low_power_osc_enable;
    logic [1:0]  port_c_direction, port_c_direction_eff;
    logic [7:0]  rd;
    int          error_cnt, cmp_count, m_cnt, t;

    sbtc_top DUT (
        .mclk(mclk), .rst_b(rst_b), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .instr_cycle_tick(instr_cycle_tick), .core_sleep(core_sleep),
        .capture_compare_reset(capture_compare_reset), .irq(irq),
        .ext_clock_pin(ext_clock_pin), .port_c_direction(port_c_direction),
        .port_c_direction_eff(port_c_direction_eff), .low_power_osc_enable(low_power_osc_enable)
    );

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // report and compare
    // ------------------------------------------------------------
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: register read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task chk_pin(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: output %b expected %b", $time, got, exp);
        end
    endtask : chk_pin

    // ------------------------------------------------------------
    // avalon master and stimulus
    // ------------------------------------------------------------
    task bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge mclk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= 4'hF;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            error_cnt++;
            $display("ERROR %0t: bus answer timed out", $time);
            end_sim();
        end
    endtask : bus

    task rdc(input logic [11:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk_reg(rd, exp);
    endtask : rdc

    task chk_cnt(input int e);
        rdc(A_LO, e[7:0]);
        rdc(A_HI, e[15:8]);
    endtask : chk_cnt

    task ticks(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            instr_cycle_tick <= 1'b1;
            @(posedge mclk);
            instr_cycle_tick <= 1'b0;
        end
    endtask : ticks

    task edges(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            ext_clock_pin <= 1'b1;
            repeat (3) @(posedge mclk);
            ext_clock_pin <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        repeat (6) @(posedge mclk);
    endtask : edges

    // clears count and prescaler, runs n events, stops and compares the model count
    task run_count(input logic [7:0] ctrl, input int n, input bit ext, input int e);
        bus(1'b1, A_CTRL, ctrl);
        bus(1'b1, A_LO, 8'h00);
        bus(1'b1, A_HI, 8'h00);
        m_cnt = e;
        if (ext)
            edges(n);
        else
            ticks(n);
        bus(1'b1, A_CTRL, ctrl & 8'hFE);
        chk_cnt(m_cnt);
        $display("count test ctrl %h done", ctrl);
    endtask : run_count

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        ce = 1'b1;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        instr_cycle_tick = 1'b0;
        core_sleep = 1'b0;
        capture_compare_reset = 1'b0;
        ext_clock_pin = 1'b0;
        port_c_direction = 2'h0;
        error_cnt = 0;
        cmp_count = 0;
        void'($urandom(87619));
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        rdc(A_CTRL, 8'h00);
        rdc(A_FLAG, 8'h00);
        rdc(A_EN, 8'h00);
        rdc(A_BAD, 8'h00);
        chk_cnt(0);
        $display("reset values test done");
        bus(1'b1, A_CTRL, 8'hFF);
        repeat (OSC_SETTLE) @(posedge mclk);
        rdc(A_CTRL, 8'h3F);
        port_c_direction <= 2'($urandom_range(0, 2));
        @(negedge mclk);
        chk_pin({1'b0, low_power_osc_enable}, 2'h1);
        chk_pin(port_c_direction_eff, 2'h3);
        bus(1'b1, A_CTRL, 8'h00);
        @(negedge mclk);
        chk_pin({1'b0, low_power_osc_enable}, 2'h0);
        chk_pin(port_c_direction_eff, port_c_direction);
        $display("control and pin test done");
        for (int ps = 0; ps < 4; ps++)
        begin
            t = $urandom_range(20, 40);
            run_count({2'b00, 2'(ps), 4'h1}, t, 1'b0, t >> ps);
        end
        t = $urandom_range(5, 20);
        run_count(8'h05, t, 1'b0, t);
        run_count(8'h00, t, 1'b0, 0);
        bus(1'b1, A_CTRL, 8'h01);
        @(posedge mclk);
        ce <= 1'b0;
        ticks(4);
        @(posedge mclk);
        ce <= 1'b1;
        bus(1'b1, A_CTRL, 8'h00);
        chk_cnt(0);
        $display("clock enable test done");
        for (int s = 0; s < 2; s++)
        begin
            t = $urandom_range(6, 16);
            run_count({4'h1, 1'b0, 1'(s), 2'h3}, t, 1'b1, t / 2);
        end
        @(posedge mclk);
        core_sleep <= 1'b1;
        run_count(8'h01, t, 1'b0, 0);
        run_count(8'h07, t, 1'b1, t);
        @(posedge mclk);
        core_sleep <= 1'b0;
        bus(1'b1, A_CTRL, 8'h01);
        ticks(5);
        @(posedge mclk);
        capture_compare_reset <= 1'b1;
        @(posedge mclk);
        capture_compare_reset <= 1'b0;
        bus(1'b1, A_CTRL, 8'h00);
        chk_cnt(0);
        $display("compare reset test done");
        bus(1'b1, A_LO, 8'hFE);
        bus(1'b1, A_HI, 8'hFF);
        bus(1'b1, A_CTRL, 8'h01);
        ticks(2);
        bus(1'b1, A_CTRL, 8'h00);
        chk_cnt(0);
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        chk_pin({1'b0, irq}, 2'h0);
        bus(1'b1, A_EN, 8'h01);
        @(negedge mclk);
        chk_pin({1'b0, irq}, 2'h1);
        rdc(A_FLAG, 8'h01);
        @(negedge mclk);
        chk_pin({1'b0, irq}, 2'h0);
        rdc(A_FLAG, 8'h00);
        $display("overflow test done");
        end_sim();
    end

    initial
    begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        $display("ERROR %0t: run limit reached", $time);
        end_sim();
    end

endmodule : sbtc_top_tb

// ---- verilog/sbtc_pkg.sv ----
package sbtc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [9:0] SBTC_IDX_FLAG    = 10'h00C;
    localparam logic [9:0] SBTC_IDX_CNT_LO  = 10'h00E;
    localparam logic [9:0] SBTC_IDX_CNT_HI  = 10'h00F;
    localparam logic [9:0] SBTC_IDX_CTRL    = 10'h010;
    localparam logic [9:0] SBTC_IDX_ENABLE  = 10'h08C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SBTC_CTRL_RUN_BIT  = 0;
    localparam int SBTC_CTRL_CS_BIT   = 1;
    localparam int SBTC_CTRL_SYNC_BIT = 2;
    localparam int SBTC_CTRL_OSC_BIT  = 3;
    localparam int SBTC_CTRL_PS_LSB   = 4;
    localparam int SBTC_OVF_BIT       = 0;

    // ------------------------------------------------------------
    // masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SBTC_CTRL_MASK   = 8'h3F;
    localparam logic [7:0]  SBTC_FLAG_MASK   = 8'h01;
    localparam logic [7:0]  SBTC_CTRL_RST    = 8'h00;
    localparam logic [7:0]  SBTC_FLAG_RST    = 8'h00;
    localparam logic [7:0]  SBTC_ENABLE_RST  = 8'h00;
    localparam logic [15:0] SBTC_COUNT_RST   = 16'h0000;
    localparam logic [15:0] SBTC_COUNT_MAX   = 16'hFFFF;
    localparam logic [1:0]  SBTC_PIN_INPUTS  = 2'h3;
    localparam logic [2:0]  SBTC_DIV_RST     = 3'h0;

    // ------------------------------------------------------------
    // prescale codes
    // ------------------------------------------------------------
    localparam logic [1:0] SBTC_PS_DIV1 = 2'h0;
    localparam logic [1:0] SBTC_PS_DIV2 = 2'h1;
    localparam logic [1:0] SBTC_PS_DIV4 = 2'h2;
    localparam logic [1:0] SBTC_PS_DIV8 = 2'h3;

    // ------------------------------------------------------------
    // bus slave states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SBTC_BUS_IDLE = 2'b00,
        SBTC_BUS_ACK  = 2'b01
    } sbtc_bus_e;

endpackage : sbtc_pkg

// ---- verilog/sbtc_prescale.sv ----
`timescale 1ns/10ps
module sbtc_prescale
    import sbtc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // control
    input  wire logic [1:0] code,
    input  wire logic       clear,
    // ticks
    input  wire logic       tick_in,
    output logic            tick_out
);

    logic [2:0] div_r;
    logic [2:0] term;

    // ------------------------------------------------------------
    // terminal count per code
    // ------------------------------------------------------------
    always_comb
    begin
        case (code)
            SBTC_PS_DIV1: term = 3'h0;
            SBTC_PS_DIV2: term = 3'h1;
            SBTC_PS_DIV4: term = 3'h3;
            SBTC_PS_DIV8: term = 3'h7;
            default:      term = 3'h0;
        endcase
    end

    // at or past terminal: a code change never strands the divider above it
    assign tick_out = tick_in & (div_r >= term);

    // ------------------------------------------------------------
    // divider count
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            div_r <= SBTC_DIV_RST;
        else if (ce)
        begin
            if (clear || tick_out)
                div_r <= SBTC_DIV_RST;
            else if (tick_in)
                div_r <= div_r + 3'h1;
        end
    end

endmodule : sbtc_prescale

// ---- verilog/sbtc_top.sv ----
`timescale 1ns/10ps
module sbtc_top
    import sbtc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // avalon-mm slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // core side
    input  wire logic        instr_cycle_tick,
    input  wire logic        core_sleep,
    input  wire logic        capture_compare_reset,
    output logic             irq,
    // pins
    input  wire logic        ext_clock_pin,
    input  wire logic [1:0]  port_c_direction,
    output logic      [1:0]  port_c_direction_eff,
    output logic             low_power_osc_enable
);

    sbtc_bus_e   bus_r;
    logic [31:0] rdata_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  flag_r;
    logic [7:0]  enable_r;
    logic [15:0] count_r;
    logic [1:0]  ext_sync_r;
    logic        ext_sync_prev_r;
    logic        ext_async_prev_r;
    logic [9:0]  idx;
    logic        access;
    logic        fire;
    logic        wr_fire;
    logic        rd_fire;
    logic        be_lo;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_ctrl;
    logic        wr_enable;
    logic        rd_flag;
    logic        run_en;
    logic        ext_sel;
    logic        async_sel;
    logic        sync_rise;
    logic        async_rise;
    logic        src_tick;
    logic        inc;
    logic        ovf;
    logic        ccp_clear;
    logic [1:0]  ps_code;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign idx       = avs_address[11:2];
    assign access    = avs_read | avs_write;
    assign fire      = access && (bus_r == SBTC_BUS_ACK) && ce;
    assign wr_fire   = fire & avs_write;
    assign rd_fire   = fire & avs_read;
    assign be_lo     = avs_byteenable[0];
    assign wr_lo     = wr_fire & be_lo & (idx == SBTC_IDX_CNT_LO);
    assign wr_hi     = wr_fire & be_lo & (idx == SBTC_IDX_CNT_HI);
    assign wr_ctrl   = wr_fire & be_lo & (idx == SBTC_IDX_CTRL);
    assign wr_enable = wr_fire & be_lo & (idx == SBTC_IDX_ENABLE);
    assign rd_flag   = rd_fire & (idx == SBTC_IDX_FLAG);

    // ce low keeps the master waiting, since nothing is taken then
    assign avs_waitrequest = access && !((bus_r == SBTC_BUS_ACK) && ce);
    assign avs_readdata    = rdata_r;

    // ------------------------------------------------------------
    // bus state: one wait cycle, answer on the second
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            bus_r <= SBTC_BUS_IDLE;
        else if (ce)
        begin
            case (bus_r)
                SBTC_BUS_IDLE: bus_r <= access ? SBTC_BUS_ACK : SBTC_BUS_IDLE;
                SBTC_BUS_ACK:  bus_r <= SBTC_BUS_IDLE;
                default:       bus_r <= SBTC_BUS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (idx)
            SBTC_IDX_FLAG:   rd_mux[7:0] = flag_r & SBTC_FLAG_MASK;
            SBTC_IDX_ENABLE: rd_mux[7:0] = enable_r & SBTC_FLAG_MASK;
            SBTC_IDX_CNT_LO: rd_mux[7:0] = count_r[7:0];
            SBTC_IDX_CNT_HI: rd_mux[7:0] = count_r[15:8];
            SBTC_IDX_CTRL:   rd_mux[7:0] = ctrl_r & SBTC_CTRL_MASK;
            default:         rd_mux      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            rdata_r <= 32'h0000_0000;
        else if (ce && (bus_r == SBTC_BUS_IDLE) && avs_read)
            rdata_r <= rd_mux;
    end

    // ------------------------------------------------------------
    // control and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            ctrl_r <= SBTC_CTRL_RST;
        else if (ce && wr_ctrl)
            ctrl_r <= avs_writedata[7:0] & SBTC_CTRL_MASK;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            enable_r <= SBTC_ENABLE_RST;
        else if (ce && wr_enable)
            enable_r <= avs_writedata[7:0] & SBTC_FLAG_MASK;
    end

    assign run_en    = ctrl_r[SBTC_CTRL_RUN_BIT];
    assign ext_sel   = ctrl_r[SBTC_CTRL_CS_BIT];
    assign async_sel = ext_sel & ctrl_r[SBTC_CTRL_SYNC_BIT];
    assign ps_code   = ctrl_r[SBTC_CTRL_PS_LSB +: 2];

    // ------------------------------------------------------------
    // oscillator and pin direction
    // ------------------------------------------------------------
    assign low_power_osc_enable = ctrl_r[SBTC_CTRL_OSC_BIT];
    assign port_c_direction_eff = low_power_osc_enable ? SBTC_PIN_INPUTS : port_c_direction;

    // ------------------------------------------------------------
    // external clock edge detection
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            ext_sync_r      <= 2'h0;
            ext_sync_prev_r <= 1'b0;
        end
        else if (ce)
        begin
            ext_sync_r      <= {ext_sync_r[0], ext_clock_pin};
            ext_sync_prev_r <= ext_sync_r[1];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            ext_async_prev_r <= 1'b0;
        else if (ce)
            ext_async_prev_r <= ext_clock_pin;
    end

    assign sync_rise  = ext_sync_r[1] & ~ext_sync_prev_r;
    assign async_rise = ext_clock_pin & ~ext_async_prev_r;

    // ------------------------------------------------------------
    // count source: sleep stops all but the asynchronous counter
    // ------------------------------------------------------------
    always_comb
    begin
        if (!ext_sel)
            src_tick = instr_cycle_tick & ~core_sleep;
        else if (async_sel)
            src_tick = async_rise;
        else
            src_tick = sync_rise & ~core_sleep;
    end

    sbtc_prescale u_prescale
    (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .ce       (ce),
        .code     (ps_code),
        .clear    (wr_lo | wr_hi),
        .tick_in  (src_tick & run_en),
        .tick_out (inc)
    );

    // ------------------------------------------------------------
    // 16-bit count: write beats compare reset beats increment
    // ------------------------------------------------------------
    assign ccp_clear = capture_compare_reset & ~async_sel;
    assign ovf       = inc & (count_r == SBTC_COUNT_MAX);

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            count_r <= SBTC_COUNT_RST;
        else if (ce)
        begin
            if (wr_lo)
                count_r[7:0] <= avs_writedata[7:0];
            else if (wr_hi)
                count_r[15:8] <= avs_writedata[7:0];
            else if (ccp_clear)
                count_r <= SBTC_COUNT_RST;
            else if (inc)
                count_r <= count_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // overflow flag: read clears, a new overflow wins
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            flag_r <= SBTC_FLAG_RST;
        else if (ce)
        begin
            if (ovf && !wr_lo && !wr_hi && !ccp_clear)
                flag_r[SBTC_OVF_BIT] <= 1'b1;
            else if (rd_flag)
                flag_r[SBTC_OVF_BIT] <= 1'b0;
        end
    end

    assign irq = flag_r[SBTC_OVF_BIT] & enable_r[SBTC_OVF_BIT];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic quiet;
    assign quiet = ce & ~wr_lo & ~wr_hi & ~ccp_clear;

    AST_PRESCALE_BYPASS: assert property (@(posedge mclk) disable iff (!rst_b)
        (ps_code == SBTC_PS_DIV1) && src_tick && run_en |-> inc)
        else $error("undivided prescale missed a tick");

    AST_CTRL_RESERVED: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_fire && (idx == SBTC_IDX_CTRL) |=> avs_readdata[7:6] == 2'b00)
        else $error("control reserved bits read nonzero");

    AST_WRAP: assert property (@(posedge mclk) disable iff (!rst_b)
        quiet && inc && (count_r == SBTC_COUNT_MAX) |=> count_r == SBTC_COUNT_RST)
        else $error("count did not wrap to zero");

    AST_OVF_SET: assert property (@(posedge mclk) disable iff (!rst_b)
        quiet && ovf |=> flag_r[SBTC_OVF_BIT] ##1 (flag_r[SBTC_OVF_BIT] || $past(rd_flag)))
        else $error("overflow flag not set or lost");

    AST_IRQ_GATED: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(irq) |-> enable_r[SBTC_OVF_BIT] && $past(ce))
        else $error("interrupt raised without enable");

    AST_HOLD_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
        !run_en && quiet |=> $stable(count_r))
        else $error("count moved while stopped");

    AST_OSC_PINS: assert property (@(posedge mclk) disable iff (!rst_b)
        ce && wr_ctrl && avs_writedata[SBTC_CTRL_OSC_BIT] |=> port_c_direction_eff == SBTC_PIN_INPUTS)
        else $error("oscillator pins not forced to inputs");

    AST_CCP_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
        ce && capture_compare_reset && !async_sel && !wr_lo && !wr_hi |=> count_r == SBTC_COUNT_RST)
        else $error("compare reset did not clear count");

    AST_TIMER_STEP: assert property (@(posedge mclk) disable iff (!rst_b)
        quiet && !ext_sel && run_en && (ps_code == SBTC_PS_DIV1) && instr_cycle_tick && !core_sleep
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("timer mode did not advance");

    AST_ASYNC_EDGE: assert property (@(posedge mclk) disable iff (!rst_b)
        quiet && async_sel && run_en && (ps_code == SBTC_PS_DIV1) && async_rise
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("asynchronous edge not counted");

    AST_SYNC_DELAY: assert property (@(posedge mclk) disable iff (!rst_b)
        ext_sel && !async_sel && ce && $rose(ext_sync_r[1]) |-> src_tick || core_sleep)
        else $error("synchronised edge not used");

    AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
        ce && rd_flag && !ovf |=> !flag_r[SBTC_OVF_BIT])
        else $error("flag read did not clear overflow");

    AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (!rst_b)
        ce && flag_r[SBTC_OVF_BIT] && !rd_flag |=> flag_r[SBTC_OVF_BIT])
        else $error("overflow flag dropped without a read");

    AST_SLEEP_ASYNC: assert property (@(posedge mclk) disable iff (!rst_b)
        quiet && async_sel && core_sleep && run_en && (ps_code == SBTC_PS_DIV1) && async_rise
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("asynchronous counter stopped in sleep");

    AST_OSC_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
        ce && wr_ctrl && !avs_writedata[SBTC_CTRL_OSC_BIT] |=> !low_power_osc_enable)
        else $error("oscillator not switched off");

    AST_SYNC_IGNORED: assert property (@(posedge mclk) disable iff (!rst_b)
        quiet && !ext_sel && ctrl_r[SBTC_CTRL_SYNC_BIT] && run_en && (ps_code == SBTC_PS_DIV1)
        && instr_cycle_tick && !core_sleep |=> count_r == $past(count_r) + 16'h0001)
        else $error("sync bit disturbed internal clock counting");

    AST_CE_FREEZE: assert property (@(posedge mclk) disable iff (!rst_b)
        !ce |=> $stable(count_r) && $stable(flag_r) && $stable(ctrl_r) && $stable(bus_r))
        else $error("state moved while clock enable low");

    COV_OVERFLOW: cover property (@(posedge mclk) disable iff (!rst_b) ovf && quiet);
    COV_IRQ:      cover property (@(posedge mclk) disable iff (!rst_b) $rose(irq));
    COV_CCP:      cover property (@(posedge mclk) disable iff (!rst_b) ccp_clear && count_r != SBTC_COUNT_RST);
    COV_DIV8:     cover property (@(posedge mclk) disable iff (!rst_b) inc && ps_code == SBTC_PS_DIV8);
    COV_SLEEP_ASYNC: cover property (@(posedge mclk) disable iff (!rst_b) inc && async_sel && core_sleep);

endmodule : sbtc_top
